// *** dv/fcq_enc_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcq_enc_model (
   // Clock
   input  wire logic       core_clk,
   // Sensor pins
   output var  logic [3:0] pins
);
   logic [1:0] p;
   initial begin
      pins = 4'h0;
      p    = 2'h0;
   end
   // ==========================================================
   // Level with hold; holds stay above the 3 cycle minimum
   task level(input int i, input logic v, input int hold);
      @(posedge core_clk);
      pins[i] <= v;
      repeat (hold) @(posedge core_clk);
   endtask : level
   // Marker raised around a single selected edge only
   task marker(input logic v);
      level(2, v, 5);
   endtask : marker
   // Gray steps: one phase moves per step, A leads B going up
   task quad(input logic up, input int n);
      repeat (n) begin
         p = up ? p + 2'h1 : p - 2'h1;
         @(posedge core_clk);
         pins[1:0] <= {p[1], p[1] ^ p[0]};
         repeat (5) @(posedge core_clk);
      end
   endtask : quad
endmodule : fcq_enc_model
`default_nettype wire

// *** dv/hs_counter_quadrature_marker_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module hs_counter_quadrature_marker_tb_top;
   logic        core_clk, nrst, wb_cyc, wb_stb, wb_we, ack, out_a, out_b;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel, pins;
   logic [31:0] wb_dat, dat_o, rdat;
   int          error_cnt, checked;
   fcq_top i_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .counter_in(pins), .compare_out_a(out_a),
      .compare_out_b(out_b));
   fcq_enc_model i_enc (.core_clk(core_clk), .pins(pins));
   // ==========================================================
   // Shared tasks
   task give_verdict;
      if (error_cnt == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task check_rng(input logic [31:0] got, input logic [31:0] lo, hi);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask : check_rng
   // Classic cycle: held until ack is sampled, then one idle cycle
   task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <=
         {2'b11, we, 4'hF, a, d};
      // Only the watchdog ends a wait for the answer
      do @(posedge core_clk);
      while (ack !== 1'b1);
      rdat = dat_o;
      {wb_cyc, wb_stb, wb_we} <= 3'b000;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rdat, exp);
   endtask : rd
   task pulse(input int i);
      i_enc.level(i, 1'b1, 5);
      i_enc.level(i, 1'b0, 5);
   endtask : pulse
   task outs(input logic [31:0] exp);
      repeat (3) @(posedge core_clk);
      check({30'h0, out_b, out_a}, exp);
   endtask : outs
   // ==========================================================
   // Scenarios
   task t_reset;
      rd(fcq_pkg::OFF_CHCFG, fcq_pkg::CHCFG_RST);
      rd(8'h20, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
      outs(32'h0000_0000);
   endtask : t_reset
   task t_total;
      wr(fcq_pkg::OFF_CHCFG, 32'h0303_0300);
      repeat (3) pulse(0);
      rd(8'h20, 32'h0000_0003);
      wr(fcq_pkg::OFF_PCLR, 32'h0000_0001);
      pulse(0);
      rd(8'h20, 32'h0000_0000);
      wr(fcq_pkg::OFF_PCLR, 32'h0000_0000);
      pulse(0);
      rd(8'h20, 32'h0000_0001);
   endtask : t_total
   task t_cmp;
      wr(fcq_pkg::OFF_OUTC, 32'h0000_0002);
      wr(fcq_pkg::OFF_PRE_A, 32'h0000_0003);
      outs(32'h0000_0000);
      repeat (2) pulse(0);
      outs(32'h0000_0001);
      wr(fcq_pkg::OFF_PRE_A, 32'h0000_0000);
      outs(32'h0000_0000);
      wr(fcq_pkg::OFF_OUTC, 32'h0000_0024);
      outs(32'h0000_0003);
      wr(fcq_pkg::OFF_OUTC, 32'h0000_0025);
      outs(32'h0000_0002);
      wr(fcq_pkg::OFF_CHCFG, 32'h0303_0000);
      wr(fcq_pkg::OFF_OUTC, 32'h0000_0010);
      outs(32'h0000_0000);
      pulse(1);
      wr(fcq_pkg::OFF_PRE_B, 32'h0000_0001);
      outs(32'h0000_0002);
      wr(fcq_pkg::OFF_PRE_B, 32'h0000_0000);
      outs(32'h0000_0000);
   endtask : t_cmp
   task t_hwclr;
      wr(fcq_pkg::OFF_CHCFG, 32'h0343_0300);
      pulse(2);
      rd(8'h20, 32'h0000_0000);
   endtask : t_hwclr
   // Tick phase is free, so each width may land one tick either way
   task t_pulse;
      wr(fcq_pkg::OFF_CHCFG, 32'h2103_0100);
      i_enc.level(1, 1'b1, 250);
      i_enc.level(1, 1'b0, 10);
      bus(1'b0, 8'h24, 32'h0000_0000);
      check_rng(rdat, 32'h0000_0002, 32'h0000_0003);
      i_enc.level(1, 1'b1, 120);
      i_enc.level(1, 1'b0, 10);
      bus(1'b0, 8'h24, 32'h0000_0000);
      check_rng(rdat, 32'h0000_0001, 32'h0000_0002);
      i_enc.level(3, 1'b1, 50);
      i_enc.level(3, 1'b0, 450);
      pulse(3);
      bus(1'b0, 8'h2C, 32'h0000_0000);
      check_rng(rdat, 32'h0000_0005, 32'h0000_0006);
   endtask : t_pulse
   task t_quad;
      wr(fcq_pkg::OFF_CHCFG, 32'h0303_0302);
      wr(fcq_pkg::OFF_REV_1, 32'h0000_0008);
      i_enc.quad(1'b1, 10);
      rd(8'h20, 32'h0000_0002);
      i_enc.quad(1'b0, 3);
      rd(8'h20, 32'h0000_0007);
      wr(fcq_pkg::OFF_PCLR, 32'h0000_0001);
      rd(8'h20, 32'h0000_0000);
      wr(fcq_pkg::OFF_PCLR, 32'h0000_0002);
      rd(8'h20, 32'h0000_0007);
      wr(fcq_pkg::OFF_PCLR, 32'h0000_0000);
      i_enc.quad(1'b1, 1);
      rd(8'h20, 32'h0000_0000);
   endtask : t_quad
   task t_marker;
      wr(fcq_pkg::OFF_MARK, 32'h0000_0003);
      i_enc.marker(1'b1);
      i_enc.quad(1'b1, 1);
      i_enc.marker(1'b0);
      rd(8'h20, 32'h0000_0000);
      i_enc.quad(1'b1, 4);
      i_enc.marker(1'b1);
      i_enc.quad(1'b0, 1);
      i_enc.marker(1'b0);
      rd(8'h20, 32'h0000_0007);
      wr(fcq_pkg::OFF_MARK, 32'h0000_0001);
      pulse(2);
      rd(8'h20, 32'h0000_0000);
      wr(fcq_pkg::OFF_CHCFG, 32'h0303_030A);
      i_enc.quad(1'b1, 1);
      rd(8'h20, 32'h0000_0007);
   endtask : t_marker
   // ==========================================================
   // Clock, reset, sequence, watchdog
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      {nrst, wb_cyc, wb_stb, wb_we} = 4'h0;
      {wb_adr, wb_dat} = 40'h00_0000_0000;
      wb_sel = 4'hF;
      error_cnt = 0;
      checked = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_total();
      t_cmp();
      t_hwclr();
      t_pulse();
      t_quad();
      t_marker();
      give_verdict();
   end
   // Tests need about 1300 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      give_verdict();
   end
endmodule : hs_counter_quadrature_marker_tb_top
`default_nettype wire

// *** src/fcq_pkg.sv ***
`default_nettype none
package fcq_pkg;
   // ==========================================================
   // Timing
   localparam int         CLK_NS    = 10;
   localparam int         TICK_NS   = 1000;
   localparam int         TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
   localparam logic [6:0] TICK_RST  = 7'h00;

   // ==========================================================
   // Register offsets (byte addresses; OFF_ACC_HI is the upper address nibble)
   localparam logic [7:0] OFF_CHCFG = 8'h00;
   localparam logic [7:0] OFF_MARK  = 8'h04;
   localparam logic [7:0] OFF_OUTC  = 8'h08;
   localparam logic [7:0] OFF_PCLR  = 8'h0C;
   localparam logic [7:0] OFF_PRE_A = 8'h10;
   localparam logic [7:0] OFF_PRE_B = 8'h14;
   localparam logic [7:0] OFF_REV_1 = 8'h18;
   localparam logic [7:0] OFF_REV_3 = 8'h1C;
   localparam logic [3:0] OFF_ACC_HI = 4'h2;
   localparam logic [7:0] OFF_STAT  = 8'h30;

   // ==========================================================
   // Reset values and constants
   localparam logic [31:0] CHCFG_RST = 32'h0303_0303;
   localparam logic [31:0] ZERO32    = 32'h0000_0000;
   localparam logic [31:0] ONE32     = 32'h0000_0001;

   // ==========================================================
   // Field encodings
   localparam logic [1:0] MODE_TOT  = 2'h0;
   localparam logic [1:0] MODE_PUL  = 2'h1;
   localparam logic [1:0] MODE_QUAD = 2'h2;
   localparam logic [1:0] MODE_OFF  = 2'h3;
   localparam logic [1:0] SUB_WH    = 2'h0;
   localparam logic [1:0] SUB_WL    = 2'h1;
   localparam logic [1:0] SUB_PR    = 2'h2;
   localparam logic [1:0] SUB_PF    = 2'h3;
   localparam logic [1:0] OUT_PLAIN = 2'h0;
   localparam logic [1:0] OUT_PWM   = 2'h1;
   localparam logic [1:0] OUT_CMP   = 2'h2;
   localparam logic [1:0] MK_RISE   = 2'h0;
   localparam logic [1:0] MK_FALL   = 2'h1;
   localparam logic [1:0] MK_BOTH   = 2'h2;

   // ==========================================================
   // Types
   typedef struct packed {
      logic       rst_fall;
      logic       rst_en;
      logic [1:0] sub;
      logic       quad_dn;
      logic       edge_fall;
      logic [1:0] mode;
   } fcq_chcfg_t;

   typedef struct packed {
      logic       lvl_low;
      logic       rst_on_fall;
      logic       on_b;
      logic [1:0] aedge;
      logic       sync;
      logic       en;
   } fcq_mark_t;

   typedef struct packed {
      logic       plain;
      logic [1:0] mode;
   } fcq_out_t;

   typedef enum logic [1:0] {
      FCQ_P_WAIT = 2'b01,
      FCQ_P_RUN  = 2'b10
   } fcq_pst_t;
endpackage : fcq_pkg
`default_nettype wire

// *** src/fcq_top.sv ***
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Program clear bit holds totalizer at zero
// - Inputs three/four clear counters one/two on edge
// - Hardware totalize clear within 100 us
// - Compare output high when count reaches preset
// - Each output: plain, PWM or compare; PWM is not built, that setting holds the output low
// - Preset changeable live; zero forces output low
// - Width sub-modes count 1 us ticks at level
// - Period sub-modes time edge to like edge
// - Accumulator holds last completed measurement
// - Quadrature on counters one and three only
// - Count every phase edge, four per cycle
// - Configurable count direction for A leading
// - Nonzero revolution count wraps; zero full range
// - Clear zeros, set loads revolution count minus one
// - Input three may act as marker
// - Async marker zeros on chosen marker edge
// - Sync marker acts on phase edge at level
// - Sync marker level sampled within 50 us
// - Reversed rotation loads revolution count minus one
// - Totalize counts one chosen edge direction
module fcq_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // Counter and marker inputs
   input  wire logic [3:0]  counter_in,
   // Digital outputs
   output var  logic        compare_out_a,
   output var  logic        compare_out_b
);
   // ==========================================================
   // Declarations
   logic [3:0]           s1_r, s2_r, s3_r, rise, fall;
   logic [6:0]           tick_r, tick_nxt;
   logic                 tick;
   fcq_pkg::fcq_chcfg_t  cfg_r [4];
   fcq_pkg::fcq_chcfg_t  cfg_nxt [4];
   fcq_pkg::fcq_mark_t   mk_r, mk_nxt;
   fcq_pkg::fcq_out_t    oc_r [2];
   fcq_pkg::fcq_out_t    oc_nxt [2];
   logic [3:0]           pclr_r, pclr_nxt;
   logic [31:0]          pre_r [2];
   logic [31:0]          pre_nxt [2];
   logic [31:0]          rev_r [2];
   logic [31:0]          rev_nxt [2];
   logic [31:0]          acc_r [4];
   logic [31:0]          acc_nxt [4];
   logic [31:0]          meas_r [4];
   logic [31:0]          meas_nxt [4];
   fcq_pkg::fcq_pst_t    pst_r [4];
   fcq_pkg::fcq_pst_t    pst_nxt [4];
   logic [1:0]           qd [4];
   logic [3:0]           act, hwr;
   logic                 mk_on, mk_async, mk_sync, s_zero;
   logic                 ahit, er, ef, cw, s_act;
   logic                 ack_nxt, wr, cmp_a_nxt, cmp_b_nxt;
   logic [31:0]          dat_nxt, rdat, wdat;

   // ==========================================================
   // Helpers
   // Returns {lead_step, lag_step}; a double change is dropped
   function automatic logic [1:0] quad_step(input logic ap, bp, a, b);
      logic one, up;
      one = (a ^ ap) ^ (b ^ bp);
      up  = (a & ~ap & ~b) | (b & ~bp & a) | (~a & ap & b)
          | (~b & bp & ~a);
      return {one & up, one & ~up};
   endfunction : quad_step

   function automatic logic [31:0] be_merge(input logic [31:0] o, n,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (sel[k]) r[8*k +: 8] = n[8*k +: 8];
      end
      return r;
   endfunction : be_merge

   // ==========================================================
   // Input synchroniser and edge detect
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
      end else begin
         s1_r <= counter_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;

   // ==========================================================
   // Microsecond time base
   always_comb begin
      tick     = (tick_r == fcq_pkg::TICK_LAST);
      tick_nxt = tick ? fcq_pkg::TICK_RST : tick_r + 7'h01;
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) tick_r <= fcq_pkg::TICK_RST;
      else       tick_r <= tick_nxt;
   end

   // ==========================================================
   // Register file
   always_comb begin
      for (int k = 0; k < 4; k++) cfg_nxt[k] = cfg_r[k];
      for (int k = 0; k < 2; k++) begin
         oc_nxt[k]  = oc_r[k];
         pre_nxt[k] = pre_r[k];
         rev_nxt[k] = rev_r[k];
      end
      mk_nxt   = mk_r;
      pclr_nxt = pclr_r;
      // Answer one cycle after the strobe, drop after one
      ack_nxt  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr       = ack_nxt & wb_we_i;
      if (wb_adr_i == fcq_pkg::OFF_CHCFG) begin
         rdat = {cfg_r[3], cfg_r[2], cfg_r[1], cfg_r[0]};
      end else if (wb_adr_i == fcq_pkg::OFF_MARK) begin
         rdat = {25'h000_0000, mk_r};
      end else if (wb_adr_i == fcq_pkg::OFF_OUTC) begin
         rdat = {26'h000_0000, oc_r[1], oc_r[0]};
      end else if (wb_adr_i == fcq_pkg::OFF_PCLR) begin
         rdat = {28'h000_0000, pclr_r};
      end else if (wb_adr_i == fcq_pkg::OFF_PRE_A) begin
         rdat = pre_r[0];
      end else if (wb_adr_i == fcq_pkg::OFF_PRE_B) begin
         rdat = pre_r[1];
      end else if (wb_adr_i == fcq_pkg::OFF_REV_1) begin
         rdat = rev_r[0];
      end else if (wb_adr_i == fcq_pkg::OFF_REV_3) begin
         rdat = rev_r[1];
      end else if (wb_adr_i[7:4] == fcq_pkg::OFF_ACC_HI) begin
         rdat = acc_r[wb_adr_i[3:2]];
      end else if (wb_adr_i == fcq_pkg::OFF_STAT) begin
         rdat = {26'h000_0000, compare_out_b, compare_out_a, s2_r};
      end else begin
         rdat = fcq_pkg::ZERO32;
      end
      wdat    = be_merge(rdat, wb_dat_i, wb_sel_i);
      dat_nxt = (ack_nxt && !wb_we_i) ? rdat : fcq_pkg::ZERO32;
      if (wr) begin
         if (wb_adr_i == fcq_pkg::OFF_CHCFG) begin
            {cfg_nxt[3], cfg_nxt[2], cfg_nxt[1], cfg_nxt[0]} = wdat;
         end else if (wb_adr_i == fcq_pkg::OFF_MARK) begin
            mk_nxt = wdat[6:0];
         end else if (wb_adr_i == fcq_pkg::OFF_OUTC) begin
            oc_nxt[0] = wdat[2:0];
            oc_nxt[1] = wdat[5:3];
         end else if (wb_adr_i == fcq_pkg::OFF_PCLR) begin
            pclr_nxt = wdat[3:0];
         end else if (wb_adr_i == fcq_pkg::OFF_PRE_A) begin
            pre_nxt[0] = wdat;
         end else if (wb_adr_i == fcq_pkg::OFF_PRE_B) begin
            pre_nxt[1] = wdat;
         end else if (wb_adr_i == fcq_pkg::OFF_REV_1) begin
            rev_nxt[0] = wdat;
         end else if (wb_adr_i == fcq_pkg::OFF_REV_3) begin
            rev_nxt[1] = wdat;
         end
      end
   end

   // ==========================================================
   // Channel routing and marker
   always_comb begin
      // A quadrature pair or a reset role takes the partner input
      mk_on  = mk_r.en && (cfg_r[0].mode == fcq_pkg::MODE_QUAD);
      act[0] = 1'b1;
      act[1] = (cfg_r[0].mode != fcq_pkg::MODE_QUAD);
      act[2] = !cfg_r[2].rst_en && !mk_on;
      act[3] = (cfg_r[2].mode != fcq_pkg::MODE_QUAD) && !cfg_r[3].rst_en;
      for (int k = 0; k < 2; k++) begin
         hwr[k] = act[k] && cfg_r[k+2].rst_en
                  && (cfg_r[k+2].rst_fall ? fall[k+2] : rise[k+2]);
      end
      hwr[3:2] = 2'b00;
      case (mk_r.aedge)
         fcq_pkg::MK_RISE: ahit = rise[2];
         fcq_pkg::MK_FALL: ahit = fall[2];
         fcq_pkg::MK_BOTH: ahit = rise[2] | fall[2];
         default:          ahit = 1'b0;
      endcase
      mk_async = mk_on && !mk_r.sync && ahit;
      er     = mk_r.on_b ? rise[1] : rise[0];
      ef     = mk_r.on_b ? fall[1] : fall[0];
      cw     = qd[0][1];
      // Marker level sampled in the same cycle as the phase edge
      s_act  = (s2_r[2] ^ mk_r.lvl_low) & ((er & cw) | (ef & ~cw));
      s_zero = (er & cw) ^ mk_r.rst_on_fall;
      mk_sync = mk_on && mk_r.sync && s_act;
   end

   // ==========================================================
   // Counter channels
   generate
      for (genvar g = 0; g < 4; g++) begin : g_ch
         localparam int IB = (g % 2 == 0) ? g + 1 : g;
         localparam int IQ = g / 2;
         logic        cup, cdn, st, sp;
         logic [31:0] n;
         assign qd[g] = quad_step(s3_r[g], s3_r[IB], s2_r[g], s2_r[IB]);
         always_comb begin
            n   = rev_r[IQ];
            cup = cfg_r[g].quad_dn ? qd[g][0] : qd[g][1];
            cdn = cfg_r[g].quad_dn ? qd[g][1] : qd[g][0];
            st  = cfg_r[g].sub[0] ? fall[g] : rise[g];
            sp  = (cfg_r[g].sub == fcq_pkg::SUB_WH
                   || cfg_r[g].sub == fcq_pkg::SUB_PF) ? fall[g] : rise[g];
            acc_nxt[g]  = acc_r[g];
            meas_nxt[g] = meas_r[g];
            pst_nxt[g]  = fcq_pkg::FCQ_P_WAIT;
            if (act[g]) begin
               case (cfg_r[g].mode)
                  fcq_pkg::MODE_TOT: begin
                     if (cfg_r[g].edge_fall ? fall[g] : rise[g]) begin
                        acc_nxt[g] = acc_r[g] + fcq_pkg::ONE32;
                     end
                     if (hwr[g]) acc_nxt[g] = fcq_pkg::ZERO32;
                     if (pclr_r[g]) acc_nxt[g] = fcq_pkg::ZERO32;
                  end
                  fcq_pkg::MODE_PUL: begin
                     case (pst_r[g])
                        fcq_pkg::FCQ_P_WAIT: begin
                           if (st) begin
                              meas_nxt[g] = fcq_pkg::ZERO32;
                              pst_nxt[g]  = fcq_pkg::FCQ_P_RUN;
                           end
                        end
                        fcq_pkg::FCQ_P_RUN: begin
                           pst_nxt[g] = fcq_pkg::FCQ_P_RUN;
                           if (sp) begin
                              acc_nxt[g]  = meas_r[g];
                              meas_nxt[g] = fcq_pkg::ZERO32;
                              if (!cfg_r[g].sub[1]) begin
                                 pst_nxt[g] = fcq_pkg::FCQ_P_WAIT;
                              end
                           end else if (tick) begin
                              meas_nxt[g] = meas_r[g] + fcq_pkg::ONE32;
                           end
                        end
                        default: pst_nxt[g] = fcq_pkg::FCQ_P_WAIT;
                     endcase
                  end
                  fcq_pkg::MODE_QUAD: begin
                     if (g % 2 == 0) begin
                        if (cup) begin
                           acc_nxt[g] = (n != fcq_pkg::ZERO32
                                         && acc_r[g] + fcq_pkg::ONE32 >= n)
                                        ? fcq_pkg::ZERO32
                                        : acc_r[g] + fcq_pkg::ONE32;
                        end else if (cdn) begin
                           acc_nxt[g] = (acc_r[g] == fcq_pkg::ZERO32)
                                        ? n - fcq_pkg::ONE32
                                        : acc_r[g] - fcq_pkg::ONE32;
                        end
                        if (g == 0 && mk_sync) begin
                           acc_nxt[g] = s_zero ? fcq_pkg::ZERO32
                                               : n - fcq_pkg::ONE32;
                        end
                        if (g == 0 && mk_async) begin
                           acc_nxt[g] = fcq_pkg::ZERO32;
                        end
                        if (pclr_r[IB]) acc_nxt[g] = n - fcq_pkg::ONE32;
                        if (pclr_r[g]) acc_nxt[g] = fcq_pkg::ZERO32;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // ==========================================================
   // Output select; PWM generation is not built, so it holds low
   always_comb begin
      case (oc_r[0].mode)
         fcq_pkg::OUT_PLAIN: cmp_a_nxt = oc_r[0].plain;
         fcq_pkg::OUT_CMP:   cmp_a_nxt = (pre_r[0] != fcq_pkg::ZERO32)
                                         && (acc_r[0] >= pre_r[0]);
         default:            cmp_a_nxt = 1'b0;
      endcase
      case (oc_r[1].mode)
         fcq_pkg::OUT_PLAIN: cmp_b_nxt = oc_r[1].plain;
         fcq_pkg::OUT_CMP:   cmp_b_nxt = (pre_r[1] != fcq_pkg::ZERO32)
                                         && (acc_r[1] >= pre_r[1]);
         default:            cmp_b_nxt = 1'b0;
      endcase
   end

   // ==========================================================
   // State registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int k = 0; k < 4; k++) begin
            cfg_r[k]  <= fcq_pkg::CHCFG_RST[8*k +: 8];
            acc_r[k]  <= fcq_pkg::ZERO32;
            meas_r[k] <= fcq_pkg::ZERO32;
            pst_r[k]  <= fcq_pkg::FCQ_P_WAIT;
         end
         for (int k = 0; k < 2; k++) begin
            oc_r[k]  <= fcq_pkg::ZERO32[2:0];
            pre_r[k] <= fcq_pkg::ZERO32;
            rev_r[k] <= fcq_pkg::ZERO32;
         end
         mk_r          <= fcq_pkg::ZERO32[6:0];
         pclr_r        <= fcq_pkg::ZERO32[3:0];
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= fcq_pkg::ZERO32;
         compare_out_a <= 1'b0;
         compare_out_b <= 1'b0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            cfg_r[k]  <= cfg_nxt[k];
            acc_r[k]  <= acc_nxt[k];
            meas_r[k] <= meas_nxt[k];
            pst_r[k]  <= pst_nxt[k];
         end
         for (int k = 0; k < 2; k++) begin
            oc_r[k]  <= oc_nxt[k];
            pre_r[k] <= pre_nxt[k];
            rev_r[k] <= rev_nxt[k];
         end
         mk_r          <= mk_nxt;
         pclr_r        <= pclr_nxt;
         wb_ack_o      <= ack_nxt;
         wb_dat_o      <= dat_nxt;
         compare_out_a <= cmp_a_nxt;
         compare_out_b <= cmp_b_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   chk_clear_holds: assert property (
      pclr_r[0] && cfg_r[0].mode == fcq_pkg::MODE_TOT
      |=> acc_r[0] == fcq_pkg::ZERO32)
      else $error("totalize clear did not zero the count");
   chk_hw_reset: assert property (
      hwr[0] && cfg_r[0].mode == fcq_pkg::MODE_TOT
      |=> acc_r[0] == fcq_pkg::ZERO32)
      else $error("hardware reset edge did not clear count");
   chk_cmp_reach: assert property (
      oc_r[0].mode == fcq_pkg::OUT_CMP && pre_r[0] != fcq_pkg::ZERO32
      && acc_r[0] >= pre_r[0] |=> compare_out_a)
      else $error("compare output low at preset");
   chk_cmp_zero: assert property (
      pre_r[1] == fcq_pkg::ZERO32 && oc_r[1].mode == fcq_pkg::OUT_CMP
      |=> !compare_out_b)
      else $error("zero preset did not hold output low");
   chk_out_select: assert property (
      oc_r[0].mode == fcq_pkg::OUT_PWM |=> !compare_out_a)
      else $error("compare drove output outside compare setting");
   chk_width_load: assert property (
      cfg_r[1].mode == fcq_pkg::MODE_PUL && cfg_r[1].sub == fcq_pkg::SUB_WH
      && pst_r[1] == fcq_pkg::FCQ_P_RUN && fall[1]
      |=> acc_r[1] == $past(meas_r[1]))
      else $error("width result not loaded at end edge");
   chk_tick_space: assert property (
      tick |=> !tick [*8])
      else $error("microsecond tick too frequent");
   chk_quad_up: assert property (
      cfg_r[0].mode == fcq_pkg::MODE_QUAD && !cfg_r[0].quad_dn
      && qd[0] == 2'b10 && !mk_on && pclr_r[1:0] == 2'b00
      && (rev_r[0] == fcq_pkg::ZERO32
          || acc_r[0] + fcq_pkg::ONE32 < rev_r[0])
      |=> acc_r[0] == $past(acc_r[0]) + fcq_pkg::ONE32)
      else $error("quadrature lead edge did not count up");
   chk_quad_wrap: assert property (
      cfg_r[0].mode == fcq_pkg::MODE_QUAD && !cfg_r[0].quad_dn
      && qd[0] == 2'b10 && rev_r[0] != fcq_pkg::ZERO32 && !mk_on
      && acc_r[0] == rev_r[0] - fcq_pkg::ONE32 && pclr_r[1:0] == 2'b00
      |=> acc_r[0] == fcq_pkg::ZERO32)
      else $error("quadrature count did not wrap");
   chk_async_mark: assert property (
      mk_async && pclr_r[1:0] == 2'b00 |=> acc_r[0] == fcq_pkg::ZERO32)
      else $error("async marker did not zero count");
endmodule : fcq_top
`default_nettype wire
